// file: design/sir_top.sv
// Interrupt, conversion timing and result readout of the sensor
// Function
// - Pad push-pull when drive type bit is 0, open-drain when 1.
// - Pad active low when polarity bit is 0, active high when 1.
// - Latch bit 1 latches pad and status; 0 latches only the data-ready status bit.
// - Status bits do not depend on pad configuration or mapping enables.
// - Watermark event reaches pad only while its mapping enable is 1.
// - Full event reaches pad only while its mapping enable is 1.
// - Watermark when fill level reaches limit; host writes both bytes together.
// - A zero watermark level never satisfies the watermark condition.
// - Watermark re-evaluated at end of transaction writing a watermark byte.
// - Full status set whenever unread byte count is at least 504.
// - Full status cleared by reading it as 1 below 504.
// - Latched mode drives pad from status, otherwise from live condition.
// - Data-ready set when results stored to result registers and FIFO.
// - Data-ready reaches pad only if enabled; reading it as 1 clears.
// - Non-latched data-ready pad contribution clears 2.5 ms after assertion.
// - Timer starts only at a data-ready event in non-latched mode.
// - Enabling data-ready mapping late keeps contribution 0 until next event.
// - Conversion time is base plus per-sensor and oversampling terms.
// - Normal mode rate is 200 Hz divided by two to the rate code, codes above 17 acting as 17.
// - Results are unsigned 24-bit; host reads them in one burst.
// - Results finishing during a burst wait in shadow until burst end.
// - Select rising edge ends the burst and updates all results at once.
// - All mapped events are ORed onto the pad.
// - Every pad pulse lasts at least 1 us.
// - After reset or soft reset the pad is push-pull, active high.
`timescale 1ns/100ps
`default_nettype none
module sir_top #(
	parameter int TICK_CYCLES = sir_pkg::TICK_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic serial_select_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [9:0] fifo_len_i,
	input wire logic [23:0] press_adc_i,
	input wire logic [23:0] temp_adc_i,
	output logic fifo_push_o,
	output logic int_pad_o,
	output logic int_pad_oe_n_o
);
	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic sel_m;
		logic sel_s;
		logic sel_d;
		logic [7:0] wtm_lo;
		logic [7:0] wtm_hi;
		logic [8:0] wtm_eff;
		logic wtm_dirty;
		logic [7:0] irq_ctrl;
		logic [7:0] pwr_ctrl;
		logic [7:0] ovs_ctrl;
		logic [7:0] rate_ctrl;
		logic fwm_st;
		logic ffull_st;
		logic drdy_st;
		logic drdy_pad;
		logic drdy_tmr_on;
		logic [11:0] drdy_tmr;
		logic [23:0] press;
		logic [23:0] temp;
		logic [23:0] press_sh;
		logic [23:0] temp_sh;
		logic sh_pend;
		logic burst;
		sir_pkg::sir_meas_t meas;
		logic [19:0] conv_cnt;
		logic [31:0] per_cnt;
		logic fifo_push;
		logic [7:0] rdata;
	} sir_top_st_t;

	localparam sir_top_st_t ST_RST = '{
		sel_m: 1'b1, sel_s: 1'b1, sel_d: 1'b1,
		wtm_lo: 8'h00, wtm_hi: 8'h00, wtm_eff: 9'h000, wtm_dirty: 1'b0,
		irq_ctrl: sir_pkg::RST_IRQ_CTRL,
		pwr_ctrl: sir_pkg::RST_PWR_CTRL,
		ovs_ctrl: sir_pkg::RST_OVS_CTRL,
		rate_ctrl: sir_pkg::RST_RATE_CTRL,
		fwm_st: 1'b0, ffull_st: 1'b0, drdy_st: 1'b0, drdy_pad: 1'b0,
		drdy_tmr_on: 1'b0, drdy_tmr: 12'h000,
		press: 24'h000000, temp: 24'h000000,
		press_sh: 24'h000000, temp_sh: 24'h000000,
		sh_pend: 1'b0, burst: 1'b0,
		meas: sir_pkg::M_IDLE, conv_cnt: 20'h00000, per_cnt: 32'h00000000,
		fifo_push: 1'b0, rdata: 8'h00
	};

	sir_top_st_t s_ff, nxt_s;
	logic tick;
	logic sel_rise;
	logic st_rd;
	logic latch;
	logic fwm_cond;
	logic ffull_cond;
	logic drdy_ev;
	logic start;
	logic burst_now;
	logic res_rd;
	logic [1:0] mode;
	logic pe;
	logic te;
	logic [19:0] tconv;
	logic [4:0] odr;
	logic [7:0] st_val;
	sir_pad_if pad_if ();

	////////////////////////////////////////////////////////////////////////
	// Time base and pad driver
	sir_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.tick_o(tick)
	);

	sir_pad u_pad (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.cfg(pad_if.pad),
		.pad_o(int_pad_o),
		.pad_oe_n_o(int_pad_oe_n_o)
	);

	assign pad_if.open_drain = s_ff.irq_ctrl[sir_pkg::B_OPEN_DRAIN];
	assign pad_if.active_high = s_ff.irq_ctrl[sir_pkg::B_ACT_HIGH];

	////////////////////////////////////////////////////////////////////////
	// Pad request
	always_comb begin
		pad_if.req = 1'b0;
		if (s_ff.irq_ctrl[sir_pkg::B_LATCH]) begin
			pad_if.req = (s_ff.fwm_st & s_ff.irq_ctrl[sir_pkg::B_FWTM_EN])
				| (s_ff.ffull_st & s_ff.irq_ctrl[sir_pkg::B_FFULL_EN]);
		end else begin
			pad_if.req = (fwm_cond & s_ff.irq_ctrl[sir_pkg::B_FWTM_EN])
				| (ffull_cond & s_ff.irq_ctrl[sir_pkg::B_FFULL_EN]);
		end
		pad_if.req = pad_if.req
			| (s_ff.drdy_pad & s_ff.irq_ctrl[sir_pkg::B_DRDY_EN]);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.fifo_push = 1'b0;
		drdy_ev = 1'b0;
		start = 1'b0;
		// Select pin synchroniser
		nxt_s.sel_m = serial_select_n_i;
		nxt_s.sel_s = s_ff.sel_m;
		nxt_s.sel_d = s_ff.sel_s;
		sel_rise = s_ff.sel_s & ~s_ff.sel_d;
		res_rd = reg_rd_i && !s_ff.sel_s && reg_addr_i >= sir_pkg::A_PRESS_XLSB
			&& reg_addr_i <= sir_pkg::A_TEMP_MSB;
		burst_now = (s_ff.burst | res_rd) & ~sel_rise;
		st_rd = reg_rd_i && (reg_addr_i == sir_pkg::A_IRQ_STATUS);
		latch = s_ff.irq_ctrl[sir_pkg::B_LATCH];
		mode = s_ff.pwr_ctrl[sir_pkg::B_MODE_LO +: 2];
		pe = s_ff.pwr_ctrl[sir_pkg::B_PRESS_EN];
		te = s_ff.pwr_ctrl[sir_pkg::B_TEMP_EN];
		odr = (s_ff.rate_ctrl[4:0] > sir_pkg::ODR_MAX)
			? sir_pkg::ODR_MAX : s_ff.rate_ctrl[4:0];
		tconv = sir_pkg::T_BASE_US;
		if (pe) begin
			tconv = tconv + sir_pkg::T_PRESS_US
				+ (sir_pkg::T_OSR_US << s_ff.ovs_ctrl[2:0]);
		end
		if (te) begin
			tconv = tconv + sir_pkg::T_TEMP_US
				+ (sir_pkg::T_OSR_US << s_ff.ovs_ctrl[5:3]);
		end

		// Register writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				sir_pkg::A_WTM_LO: begin
					nxt_s.wtm_lo = reg_wdata_i;
					nxt_s.wtm_dirty = 1'b1;
				end
				sir_pkg::A_WTM_HI: begin
					nxt_s.wtm_hi = {7'h00, reg_wdata_i[0]};
					nxt_s.wtm_dirty = 1'b1;
				end
				sir_pkg::A_IRQ_CTRL: nxt_s.irq_ctrl = reg_wdata_i & 8'h5F;
				sir_pkg::A_PWR_CTRL: nxt_s.pwr_ctrl = reg_wdata_i & 8'h33;
				sir_pkg::A_OVS_CTRL: nxt_s.ovs_ctrl = reg_wdata_i & 8'h3F;
				sir_pkg::A_RATE_CTRL: nxt_s.rate_ctrl = reg_wdata_i & 8'h1F;
				default: begin
				end
			endcase
		end

		// Watermark takes effect when the writing transaction ends
		if (sel_rise && s_ff.wtm_dirty) begin
			nxt_s.wtm_eff = {s_ff.wtm_hi[0], s_ff.wtm_lo};
			nxt_s.wtm_dirty = 1'b0;
		end

		// Sampling period in normal mode
		if (mode == sir_pkg::MODE_NORMAL) begin
			if (tick) begin
				if (s_ff.per_cnt == 32'h00000000) begin
					nxt_s.per_cnt = (sir_pkg::PERIOD_US << odr) - 32'h00000001;
					start = 1'b1;
				end else begin
					nxt_s.per_cnt = s_ff.per_cnt - 32'h00000001;
				end
			end
		end else begin
			nxt_s.per_cnt = 32'h00000000;
			start = (mode != sir_pkg::MODE_SLEEP);
		end

		// Conversion sequencer
		unique case (s_ff.meas)
			sir_pkg::M_IDLE: begin
				if (start && (pe || te)) begin
					nxt_s.conv_cnt = tconv - 20'h00001;
					nxt_s.meas = sir_pkg::M_CONV;
				end else if (start && mode != sir_pkg::MODE_NORMAL) begin
					nxt_s.pwr_ctrl[sir_pkg::B_MODE_LO +: 2] = sir_pkg::MODE_SLEEP;
				end
			end
			sir_pkg::M_CONV: begin
				if (tick) begin
					if (s_ff.conv_cnt == 20'h00000) begin
						nxt_s.meas = sir_pkg::M_DONE;
					end else begin
						nxt_s.conv_cnt = s_ff.conv_cnt - 20'h00001;
					end
				end
			end
			sir_pkg::M_DONE: begin
				nxt_s.fifo_push = 1'b1;
				drdy_ev = 1'b1;
				if (burst_now) begin
					nxt_s.press_sh = pe ? press_adc_i : s_ff.press;
					nxt_s.temp_sh = te ? temp_adc_i : s_ff.temp;
					nxt_s.sh_pend = 1'b1;
				end else begin
					if (pe) begin
						nxt_s.press = press_adc_i;
					end
					if (te) begin
						nxt_s.temp = temp_adc_i;
					end
				end
				if (mode != sir_pkg::MODE_NORMAL) begin
					nxt_s.pwr_ctrl[sir_pkg::B_MODE_LO +: 2] = sir_pkg::MODE_SLEEP;
				end
				nxt_s.meas = sir_pkg::M_IDLE;
			end
		endcase

		// Burst tracking and shadow transfer
		if (res_rd) begin
			nxt_s.burst = 1'b1;
		end
		if (sel_rise) begin
			nxt_s.burst = 1'b0;
			if (s_ff.sh_pend) begin
				nxt_s.press = s_ff.press_sh;
				nxt_s.temp = s_ff.temp_sh;
				nxt_s.sh_pend = 1'b0;
			end
		end

		// Interrupt conditions and status, independent of pad settings
		fwm_cond = (s_ff.wtm_eff != 9'h000)
			&& (fifo_len_i >= {1'b0, s_ff.wtm_eff});
		ffull_cond = (fifo_len_i >= sir_pkg::FULL_LEVEL);
		nxt_s.fwm_st = fwm_cond
			| (latch & s_ff.fwm_st & ~st_rd);
		nxt_s.ffull_st = ffull_cond
			| (latch & s_ff.ffull_st & ~st_rd);
		nxt_s.drdy_st = drdy_ev | (s_ff.drdy_st & ~st_rd);

		// Data-ready pad contribution and self-clear timer
		if (drdy_ev) begin
			nxt_s.drdy_pad = s_ff.irq_ctrl[sir_pkg::B_DRDY_EN];
			nxt_s.drdy_tmr_on = ~latch;
			nxt_s.drdy_tmr = sir_pkg::DRDY_CLR_US - 12'h001;
		end else begin
			if (st_rd && s_ff.drdy_st) begin
				nxt_s.drdy_pad = 1'b0;
			end
			if (!s_ff.irq_ctrl[sir_pkg::B_DRDY_EN]) begin
				nxt_s.drdy_pad = 1'b0;
			end
			if (latch) begin
				nxt_s.drdy_tmr_on = 1'b0;
			end else if (s_ff.drdy_tmr_on && tick) begin
				if (s_ff.drdy_tmr == 12'h000) begin
					nxt_s.drdy_pad = 1'b0;
					nxt_s.drdy_tmr_on = 1'b0;
				end else begin
					nxt_s.drdy_tmr = s_ff.drdy_tmr - 12'h001;
				end
			end
		end

		// Register read data
		st_val = 8'h00;
		st_val[sir_pkg::B_ST_FWM] = s_ff.fwm_st;
		st_val[sir_pkg::B_ST_FFULL] = s_ff.ffull_st;
		st_val[sir_pkg::B_ST_DRDY] = s_ff.drdy_st;
		nxt_s.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				sir_pkg::A_PRESS_XLSB: nxt_s.rdata = s_ff.press[7:0];
				sir_pkg::A_PRESS_LSB: nxt_s.rdata = s_ff.press[15:8];
				sir_pkg::A_PRESS_MSB: nxt_s.rdata = s_ff.press[23:16];
				sir_pkg::A_TEMP_XLSB: nxt_s.rdata = s_ff.temp[7:0];
				sir_pkg::A_TEMP_LSB: nxt_s.rdata = s_ff.temp[15:8];
				sir_pkg::A_TEMP_MSB: nxt_s.rdata = s_ff.temp[23:16];
				sir_pkg::A_IRQ_STATUS: nxt_s.rdata = st_val;
				sir_pkg::A_WTM_LO: nxt_s.rdata = s_ff.wtm_lo;
				sir_pkg::A_WTM_HI: nxt_s.rdata = s_ff.wtm_hi;
				sir_pkg::A_IRQ_CTRL: nxt_s.rdata = s_ff.irq_ctrl;
				sir_pkg::A_PWR_CTRL: nxt_s.rdata = s_ff.pwr_ctrl;
				sir_pkg::A_OVS_CTRL: nxt_s.rdata = s_ff.ovs_ctrl;
				sir_pkg::A_RATE_CTRL: nxt_s.rdata = s_ff.rate_ctrl;
				default: nxt_s.rdata = 8'h00;
			endcase
		end

		// Soft reset restores defaults, keeping the synchroniser
		if (reg_wr_i && reg_addr_i == sir_pkg::A_CMD
			&& reg_wdata_i == sir_pkg::CMD_SOFTRESET) begin
			nxt_s = ST_RST;
			nxt_s.sel_m = serial_select_n_i;
			nxt_s.sel_s = s_ff.sel_m;
			nxt_s.sel_d = s_ff.sel_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff <= ST_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign reg_rdata_o = s_ff.rdata;
	assign fifo_push_o = s_ff.fifo_push;
endmodule // sir_top
`default_nettype wire

// file: design/sir_pkg.sv
// Constants and types shared by the sensor interrupt and readout logic
`default_nettype none
package sir_pkg;
	// Clock and time base
	localparam int CLK_NS = 25;
	localparam int US_NS = 1000;
	localparam int TICK_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int MIN_PULSE_NS = 1000;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// Timings in microseconds
	localparam logic [11:0] DRDY_CLR_US = 12'd2500;
	localparam logic [19:0] T_BASE_US = 20'd234;
	localparam logic [19:0] T_PRESS_US = 20'd392;
	localparam logic [19:0] T_TEMP_US = 20'd313;
	localparam logic [19:0] T_OSR_US = 20'd2000;
	localparam int SAMPLE_HZ = 200;
	localparam logic [31:0] PERIOD_US = 32'(1000000 / SAMPLE_HZ);
	localparam logic [4:0] ODR_MAX = 5'd17;
	localparam logic [9:0] FULL_LEVEL = 10'd504;
	// Register offsets
	localparam logic [7:0] A_PRESS_XLSB = 8'h04;
	localparam logic [7:0] A_PRESS_LSB = 8'h05;
	localparam logic [7:0] A_PRESS_MSB = 8'h06;
	localparam logic [7:0] A_TEMP_XLSB = 8'h07;
	localparam logic [7:0] A_TEMP_LSB = 8'h08;
	localparam logic [7:0] A_TEMP_MSB = 8'h09;
	localparam logic [7:0] A_IRQ_STATUS = 8'h11;
	localparam logic [7:0] A_WTM_LO = 8'h15;
	localparam logic [7:0] A_WTM_HI = 8'h16;
	localparam logic [7:0] A_IRQ_CTRL = 8'h19;
	localparam logic [7:0] A_PWR_CTRL = 8'h1B;
	localparam logic [7:0] A_OVS_CTRL = 8'h1C;
	localparam logic [7:0] A_RATE_CTRL = 8'h1D;
	localparam logic [7:0] A_CMD = 8'h7E;
	localparam logic [7:0] CMD_SOFTRESET = 8'hB6;
	// Reset values
	localparam logic [7:0] RST_IRQ_CTRL = 8'h02;
	localparam logic [7:0] RST_PWR_CTRL = 8'h00;
	localparam logic [7:0] RST_OVS_CTRL = 8'h02;
	localparam logic [7:0] RST_RATE_CTRL = 8'h00;
	// Field positions
	localparam int B_OPEN_DRAIN = 0;
	localparam int B_ACT_HIGH = 1;
	localparam int B_LATCH = 2;
	localparam int B_FWTM_EN = 3;
	localparam int B_FFULL_EN = 4;
	localparam int B_DRDY_EN = 6;
	localparam int B_PRESS_EN = 0;
	localparam int B_TEMP_EN = 1;
	localparam int B_MODE_LO = 4;
	localparam int B_ST_FWM = 0;
	localparam int B_ST_FFULL = 1;
	localparam int B_ST_DRDY = 3;
	localparam logic [1:0] MODE_SLEEP = 2'b00;
	localparam logic [1:0] MODE_NORMAL = 2'b11;
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_CONV = 3'b010,
		M_DONE = 3'b100
	} sir_meas_t;
endpackage
`default_nettype wire

// file: design/sir_pad_if.sv
// Carrier between the interrupt logic and the pad driver
`timescale 1ns/100ps
`default_nettype none
interface sir_pad_if;
	logic req;
	logic open_drain;
	logic active_high;
	modport src (output req, output open_drain, output active_high);
	modport pad (input req, input open_drain, input active_high);
endinterface
`default_nettype wire

// file: design/sir_tick.sv
// Microsecond enable divider
`timescale 1ns/100ps
`default_nettype none
module sir_tick #(
	parameter int TICK_CYCLES = sir_pkg::TICK_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} sir_tick_st_t;
	sir_tick_st_t s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.tick = (s_ff.cnt == 16'(TICK_CYCLES - 1));
		nxt_s.cnt = nxt_s.tick ? 16'h0000 : s_ff.cnt + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tick_o = s_ff.tick;
endmodule // sir_tick
`default_nettype wire

// file: design/sir_pad.sv
// Interrupt pad driver with polarity, drive type and pulse stretch
`timescale 1ns/100ps
`default_nettype none
module sir_pad (
	input wire logic clk_i,
	input wire logic arst_n_i,
	sir_pad_if.pad cfg,
	output logic pad_o,
	output logic pad_oe_n_o
);
	typedef struct packed {
		logic [5:0] cnt;
		logic req_d;
		logic pad;
		logic oe_n;
	} sir_pad_st_t;
	sir_pad_st_t s_ff, nxt_s;
	logic act;
	logic lvl;

	always_comb begin
		nxt_s = s_ff;
		act = cfg.req | (s_ff.cnt != 6'h00);
		if (cfg.req && !s_ff.req_d) begin
			nxt_s.cnt = 6'(sir_pkg::MIN_PULSE_CYC - 1);
		end else if (s_ff.cnt != 6'h00) begin
			nxt_s.cnt = s_ff.cnt - 6'h01;
		end
		nxt_s.req_d = cfg.req;
		lvl = cfg.active_high ? act : ~act;
		nxt_s.pad = lvl;
		nxt_s.oe_n = cfg.open_drain ? lvl : 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_ff <= '{cnt: 6'h00, req_d: 1'b0, pad: 1'b0, oe_n: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign pad_o = s_ff.pad;
	assign pad_oe_n_o = s_ff.oe_n;
endmodule // sir_pad
`default_nettype wire

// file: test/sir_top_asserts.sv
// Checker of the sensor interrupt and readout block
`timescale 1ns/100ps
`default_nettype none
module sir_top_asserts #(
	parameter int TICK_CYCLES = 40
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic serial_select_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [9:0] fifo_len_i,
	input wire logic [23:0] press_adc_i,
	input wire logic [23:0] temp_adc_i,
	input wire logic fifo_push_o,
	input wire logic int_pad_o,
	input wire logic int_pad_oe_n_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic [7:0] ctrl_ff;
	logic [5:0] stab_ff;
	logic [6:0] act_ff;
	logic pend_ff;
	logic act, wctl, wcmd, rdst, rres;
	assign act = int_pad_o == ctrl_ff[sir_pkg::B_ACT_HIGH];
	assign wctl = reg_wr_i && reg_addr_i == sir_pkg::A_IRQ_CTRL;
	assign wcmd = reg_wr_i && reg_addr_i == sir_pkg::A_CMD
		&& reg_wdata_i == sir_pkg::CMD_SOFTRESET;
	assign rdst = reg_rd_i && reg_addr_i == sir_pkg::A_IRQ_STATUS;
	assign rres = reg_rd_i && reg_addr_i >= sir_pkg::A_PRESS_XLSB
		&& reg_addr_i <= sir_pkg::A_TEMP_MSB;
	////////////////////////////////////////////////////////////////////////
	// Mirror of the pad control and helper counters
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_ff <= sir_pkg::RST_IRQ_CTRL;
			stab_ff <= 6'h00;
			act_ff <= 7'h00;
			pend_ff <= 1'b0;
		end else begin
			if (wctl) begin
				ctrl_ff <= reg_wdata_i & 8'h5F;
			end else if (wcmd) begin
				ctrl_ff <= sir_pkg::RST_IRQ_CTRL;
			end
			stab_ff <= (wctl || wcmd) ? 6'h00 :
				stab_ff + {5'h00, stab_ff != 6'h3F};
			act_ff <= act ? act_ff + {6'h00, act_ff != 7'h7F} : 7'h00;
			pend_ff <= fifo_push_o || (pend_ff && !rdst && !wcmd);
		end
	end
	////////////////////////////////////////////////////////////////////////
	pad_drive_a: assert property (
		stab_ff >= 6'd3 |-> int_pad_oe_n_o == (ctrl_ff[0] & int_pad_o))
		else $error("Pad drive enable wrong");
	idle_level_a: assert property (
		stab_ff >= 6'd50 && (ctrl_ff & 8'h58) == 8'h00
		|-> int_pad_o == !ctrl_ff[1]) else $error("Unmapped pad not idle");
	pulse_width_a: assert property (
		$fell(act) && stab_ff >= 6'd3 |-> act_ff >= 7'd38)
		else $error("Pad pulse too short");
	full_status_a: assert property (
		rdst && fifo_len_i >= sir_pkg::FULL_LEVEL
		&& $past(fifo_len_i) >= sir_pkg::FULL_LEVEL
		&& $past(fifo_len_i, 2) >= sir_pkg::FULL_LEVEL
		|=> reg_rdata_o[sir_pkg::B_ST_FFULL]) else $error("Full status low");
	drdy_set_a: assert property (
		rdst && pend_ff && !fifo_push_o |=> reg_rdata_o[sir_pkg::B_ST_DRDY])
		else $error("Data ready status missing");
	drdy_clear_a: assert property (
		(rdst && !fifo_push_o) ##1 (reg_rdata_o[3] && !fifo_push_o)
		##1 (rdst && !fifo_push_o) |=> !reg_rdata_o[3])
		else $error("Data ready not cleared by read");
	push_pulse_a: assert property (
		fifo_push_o |=> !fifo_push_o) else $error("Store pulse too long");
	burst_hold_a: assert property (
		(rres && !serial_select_n_i && !$past(serial_select_n_i, 3))
		##1 !serial_select_n_i ##1 (reg_rd_i && !serial_select_n_i
		&& reg_addr_i == $past(reg_addr_i, 2))
		|=> reg_rdata_o == $past(reg_rdata_o, 2)) else $error("Result moved");
	push_c: cover property (fifo_push_o);
	pad_c: cover property ($rose(act));
	drdy_c: cover property (rdst ##1 reg_rdata_o[3]);
endmodule // sir_top_asserts
bind sir_top sir_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk_i(clk_i), .arst_n_i(arst_n_i),
	.serial_select_n_i(serial_select_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .fifo_len_i(fifo_len_i),
	.press_adc_i(press_adc_i), .temp_adc_i(temp_adc_i),
	.fifo_push_o(fifo_push_o), .int_pad_o(int_pad_o),
	.int_pad_oe_n_o(int_pad_oe_n_o)
);
`default_nettype wire

// file: test/sir_host_model.sv
// Host model driving the register port and the serial select
`timescale 1ns/100ps
`default_nettype none
module sir_host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic select_n_o,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		select_n_o = 1'b1;
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// Select rise closes the transaction
	task automatic sel(input logic lvl);
		@(negedge clk_i);
		select_n_o = lvl;
		repeat (2) @(negedge clk_i);
	endtask
	// Data shows its inverse once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
	// Both watermark bytes in one transaction
	task automatic wtm(input logic [9:0] lvl);
		sel(1'b0);
		wr(sir_pkg::A_WTM_LO, lvl[7:0]);
		wr(sir_pkg::A_WTM_HI, {6'h00, lvl[9:8]});
		sel(1'b1);
	endtask
	// One 24-bit result fetched in a single burst
	task automatic burst(input logic [7:0] a, output logic [23:0] v);
		logic [7:0] b;
		sel(1'b0);
		for (int i = 0; i < 3; i++) begin
			rd(a + 8'(i), b);
			v[8*i +: 8] = b;
		end
		sel(1'b1);
	endtask
endmodule // sir_host_model
`default_nettype wire

// file: test/sir_top_test.sv
// Self-checking bench of the sensor interrupt and readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
	n_tests++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("[FAIL] %s exp %0h got %0h", nm, e, g); \
	end
module sir_top_test;
	localparam int TK = 2;
	localparam int T1 = (234 + 392 + 2000) * TK;
	localparam int T2 = (234 + 392 + 2000 + 313 + 2000) * TK;
	localparam int T3 = 5000 * TK;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [9:0] len;
		logic [9:0] wtm;
		logic pad;
		logic oe_n;
		logic [7:0] st;
	} sir_row_t;
	localparam sir_row_t ROWS [10] = '{
		'{8'h02, 10'd10, 10'd5, 1'b0, 1'b0, 8'h01},
		'{8'h0A, 10'd10, 10'd5, 1'b1, 1'b0, 8'h01},
		'{8'h08, 10'd10, 10'd5, 1'b0, 1'b0, 8'h01},
		'{8'h09, 10'd10, 10'd5, 1'b0, 1'b0, 8'h01},
		'{8'h0B, 10'd10, 10'd5, 1'b1, 1'b1, 8'h01},
		'{8'h12, 10'd504, 10'd0, 1'b1, 1'b0, 8'h02},
		'{8'h12, 10'd503, 10'd0, 1'b0, 1'b0, 8'h00},
		'{8'h1A, 10'd504, 10'd505, 1'b1, 1'b0, 8'h02},
		'{8'h0A, 10'd10, 10'd11, 1'b0, 1'b0, 8'h00},
		'{8'h0A, 10'd11, 10'd11, 1'b1, 1'b0, 8'h01}};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [9:0] fifo_len = 10'h000;
	logic [23:0] press_adc = 24'h000000;
	logic [23:0] temp_adc = 24'h000000;
	wire logic sel_n, wr, rd, fpush, pad, oe_n;
	wire logic [7:0] addr, wdata, rdata;
	logic [7:0] d;
	logic [23:0] v;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	always #12.5 clk = ~clk;
	sir_host_model u_host (
		.clk_i(clk), .rdata_i(rdata), .select_n_o(sel_n), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata)
	);
	sir_top #(.TICK_CYCLES(TK)) u_dut (
		.clk_i(clk), .arst_n_i(arst_n), .serial_select_n_i(sel_n),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .fifo_len_i(fifo_len),
		.press_adc_i(press_adc), .temp_adc_i(temp_adc),
		.fifo_push_o(fpush), .int_pad_o(pad), .int_pad_oe_n_o(oe_n)
	);
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_push;
		n = 0;
		while (fpush !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		for (int i = 0; i < 10; i++) begin
			u_host.wtm(ROWS[i].wtm);
			u_host.wr(sir_pkg::A_IRQ_CTRL, ROWS[i].ctrl);
			fifo_len = ROWS[i].len;
			repeat (60) @(negedge clk);
			`CHK("pad", ROWS[i].pad, pad)
			`CHK("oe_n", ROWS[i].oe_n, oe_n)
			u_host.rd(sir_pkg::A_IRQ_STATUS, d);
			`CHK("status", ROWS[i].st, d)
		end
		u_host.sel(1'b0);
		u_host.wr(sir_pkg::A_WTM_LO, 8'h0C);
		u_host.wr(sir_pkg::A_WTM_HI, 8'h00);
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("wtm_old", 8'h01, d)
		u_host.sel(1'b1);
		repeat (5) @(negedge clk);
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("wtm_new", 8'h00, d)
		u_host.wr(sir_pkg::A_IRQ_CTRL, 8'h16);
		fifo_len = 10'd504;
		repeat (60) @(negedge clk);
		fifo_len = 10'd0;
		repeat (60) @(negedge clk);
		`CHK("latched_pad", 1'b1, pad)
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("latched_st", 8'h03, d)
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("read_clear", 8'h00, d)
		repeat (60) @(negedge clk);
		`CHK("cleared_pad", 1'b0, pad)
		u_host.wr(sir_pkg::A_IRQ_CTRL, 8'h42);
		u_host.wr(sir_pkg::A_OVS_CTRL, 8'h00);
		press_adc = 24'hA1B2C3;
		u_host.wr(sir_pkg::A_PWR_CTRL, 8'h11);
		wait_push();
		`CHK("tconv", 1'b1, n >= T1 - 8 && n <= T1 + 8)
		repeat (2) @(negedge clk);
		`CHK("drdy_pad", 1'b1, pad)
		u_host.burst(sir_pkg::A_PRESS_XLSB, v);
		`CHK("press", 24'hA1B2C3, v)
		repeat (2500 * TK - 100) @(negedge clk);
		`CHK("drdy_hold", 1'b1, pad)
		repeat (200) @(negedge clk);
		`CHK("drdy_self", 1'b0, pad)
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("drdy_st", 8'h08, d)
		u_host.rd(sir_pkg::A_IRQ_STATUS, d);
		`CHK("drdy_clr", 8'h00, d)
		press_adc = 24'h123456;
		temp_adc = 24'h654321;
		u_host.wr(sir_pkg::A_IRQ_CTRL, 8'h02);
		u_host.wr(sir_pkg::A_PWR_CTRL, 8'h13);
		repeat (T2 - 100) @(negedge clk);
		u_host.sel(1'b0);
		u_host.rd(sir_pkg::A_PRESS_XLSB, d);
		`CHK("burst_open", 8'hC3, d)
		wait_push();
		u_host.rd(sir_pkg::A_PRESS_XLSB, d);
		u_host.rd(sir_pkg::A_PRESS_XLSB, d);
		`CHK("shadow", 8'hC3, d)
		u_host.sel(1'b1);
		repeat (5) @(negedge clk);
		u_host.burst(sir_pkg::A_TEMP_XLSB, v);
		`CHK("temp", 24'h654321, v)
		u_host.wr(sir_pkg::A_IRQ_CTRL, 8'h42);
		repeat (5) @(negedge clk);
		`CHK("late_map", 1'b0, pad)
		u_host.wr(sir_pkg::A_PWR_CTRL, 8'h31);
		wait_push();
		repeat (2) @(negedge clk);
		wait_push();
		`CHK("odr", 1'b1, n >= T3 - 10 && n <= T3 + 8)
		arst_n = 1'b0;
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("rst_pad", 2'b00, {pad, oe_n})
		u_host.wr(sir_pkg::A_IRQ_CTRL, 8'h09);
		u_host.wr(sir_pkg::A_CMD, sir_pkg::CMD_SOFTRESET);
		u_host.rd(sir_pkg::A_IRQ_CTRL, d);
		`CHK("soft_rst", sir_pkg::RST_IRQ_CTRL, d)
		end_sim();
	end
endmodule // sir_top_test
`default_nettype wire
